// >>> design/tnco_ctrl.sv
// Timing oscillator control: APB registers, holding/active transfer, phase accumulator
// Behaviour
// R01: All configuration, frequency and phase words live in the single pclk domain.
// R02: Sync enable bit 5 clear: external sync input has no effect.
// R03: Sync enable set and sync asserted: both held words copy to active registers.
// R04: Config bits 4-3 select 8, 16, 24 or 32 offset frequency bits.
// R05: Config bit 2 clear feeds zero offset; set passes the offset through.
// R06: Config bit 1 set forces accumulator feedback to zero.
// R07: Config bit 0 set: frequency strobe or sync load also zeroes accumulator feedback.
// R08: Center frequency is a full 32-bit word, software scales it.
// R09: Frequency hold reaches active only via frequency strobe or qualifying sync.
// R10: Phase offset is an 8-bit field, signed or offset binary by software.
// R11: Phase hold reaches active only via phase strobe or qualifying sync.
// R12: Any write to frequency strobe moves held frequency to active.
// R13: Any write to phase strobe moves held phase to active.
// R14: Per sample add frequency plus gated offset, then add phase offset.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module tnco_ctrl #(
	parameter int ACC_WIDTH = 32
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        external_sync_input,
	input  wire logic        sample_strobe,
	input  wire logic [31:0] offset_freq,
	output logic      [31:0] phase_out,
	output logic             phase_valid,
	output logic      [31:0] active_freq,
	output logic      [7:0]  active_phase
);
	logic [tnco_pkg::CFG_WIDTH-1:0]   config_reg;
	logic [31:0]                      freq_hold_reg;
	logic [tnco_pkg::PHASE_WIDTH-1:0] phase_hold_reg;
	logic [ACC_WIDTH-1:0]             acc_reg;
	logic                             zero_pend_reg;
	logic                             sync_pulse;
	logic                             sync_load;
	logic                             wr_en;
	logic                             rd_en;
	logic                             freq_strobe;
	logic                             phase_strobe;
	logic                             addr_ok;
	logic [31:0]                      gated_ofs;
	logic [31:0]                      rd_data;
	logic [31:0]                      acc_feedback;
	logic [31:0]                      acc_sum;

	tnco_sync u_sync (
		.pclk       (pclk),
		.presetn    (presetn),
		.async_in   (external_sync_input),
		.rise_pulse (sync_pulse)
	);

	tnco_ofs_gate u_ofs (
		.pclk      (pclk),
		.presetn   (presetn),
		.ofs_in    (offset_freq),
		.width_sel (config_reg[tnco_pkg::CFG_OFS_W_HI:tnco_pkg::CFG_OFS_W_LO]),
		.enable    (config_reg[tnco_pkg::CFG_OFS_EN_BIT]),
		.ofs_out   (gated_ofs)
	);

	// Zero-wait APB slave: access phase completes in its first cycle
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign freq_strobe  = wr_en & (paddr == tnco_pkg::ADDR_FREQ_STROBE); // [R12]
	assign phase_strobe = wr_en & (paddr == tnco_pkg::ADDR_PHASE_STROBE); // [R13]
	assign sync_load    = sync_pulse & config_reg[tnco_pkg::CFG_SYNC_EN_BIT]; // [R02] [R03]

	always_comb begin
		addr_ok = 1'b1;
		rd_data = 32'h0000_0000;
		unique case (paddr)
			tnco_pkg::ADDR_CONFIG:       rd_data = {26'h0, config_reg};
			tnco_pkg::ADDR_FREQ_HOLD:    rd_data = freq_hold_reg;
			tnco_pkg::ADDR_PHASE_HOLD:   rd_data = {24'h0, phase_hold_reg};
			tnco_pkg::ADDR_FREQ_STROBE:  rd_data = active_freq;
			tnco_pkg::ADDR_PHASE_STROBE: rd_data = {24'h0, active_phase};
			tnco_pkg::ADDR_STATUS:       rd_data = {31'h0, zero_pend_reg};
			tnco_pkg::ADDR_ACC:          rd_data = acc_reg[ACC_WIDTH-1 -: 32];
			default:                     addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (psel & ~penable & ~pwrite) begin
				prdata <= rd_data;
			end
		end
	end

	// Register writes complete at the edge where pready is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_reg     <= tnco_pkg::CONFIG_RESET[tnco_pkg::CFG_WIDTH-1:0];
			freq_hold_reg  <= tnco_pkg::FREQ_RESET;
			phase_hold_reg <= tnco_pkg::PHASE_RESET;
		end else if (wr_en & pready) begin // [R01]
			if (paddr == tnco_pkg::ADDR_CONFIG) begin
				config_reg <= pwdata[tnco_pkg::CFG_WIDTH-1:0];
			end
			if (paddr == tnco_pkg::ADDR_FREQ_HOLD) begin
				freq_hold_reg <= pwdata; // [R08]
			end
			if (paddr == tnco_pkg::ADDR_PHASE_HOLD) begin
				phase_hold_reg <= pwdata[tnco_pkg::PHASE_WIDTH-1:0]; // [R10]
			end
		end
	end

	// Active registers change only on a strobe or a qualifying sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_freq  <= tnco_pkg::FREQ_RESET;
			active_phase <= tnco_pkg::PHASE_RESET;
		end else begin
			if ((freq_strobe & pready) | sync_load) begin
				active_freq <= freq_hold_reg; // [R09] [R12] [R03]
			end
			if ((phase_strobe & pready) | sync_load) begin
				active_phase <= phase_hold_reg; // [R11] [R13] [R03]
			end
		end
	end

	// Load-zero request is held until the next sample so no sample edge is missed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_pend_reg <= 1'b0;
		end else if (config_reg[tnco_pkg::CFG_LOAD_ZERO_BIT] &
		             ((freq_strobe & pready) | sync_load)) begin
			zero_pend_reg <= 1'b1; // [R07]
		end else if (sample_strobe) begin
			zero_pend_reg <= 1'b0;
		end
	end

	always_comb begin
		if (config_reg[tnco_pkg::CFG_CLR_ACC_BIT] | zero_pend_reg) begin
			acc_feedback = 32'h0000_0000; // [R06] [R07]
		end else begin
			acc_feedback = acc_reg[ACC_WIDTH-1 -: 32];
		end
		acc_sum = acc_feedback + active_freq + gated_ofs; // [R14]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg <= '0;
		end else if (sample_strobe) begin
			acc_reg[ACC_WIDTH-1 -: 32] <= acc_sum;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_out   <= 32'h0000_0000;
			phase_valid <= 1'b0;
		end else begin
			phase_valid <= sample_strobe;
			if (sample_strobe) begin
				phase_out <= acc_sum + {active_phase, 24'h00_0000}; // [R14]
			end
		end
	end

	property p_sync_ignored;
		@(posedge pclk) disable iff (!presetn)
		(sync_pulse & ~config_reg[tnco_pkg::CFG_SYNC_EN_BIT] & ~(wr_en & pready))
		|=> $stable(active_freq) && $stable(active_phase);
	endproperty
	AST_SYNC_IGNORED: assert property (p_sync_ignored) // [R02]
		else $error("Sync changed active words while disabled");

	AST_SYNC_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
		sync_load |=> active_freq == $past(freq_hold_reg) && active_phase == $past(phase_hold_reg))
		else $error("Sync did not load held words");

	AST_FREQ_STROBE: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(freq_strobe & pready) |=> active_freq == $past(freq_hold_reg))
		else $error("Frequency strobe did not transfer");

	AST_PHASE_STROBE: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		(phase_strobe & pready) |=> active_phase == $past(phase_hold_reg))
		else $error("Phase strobe did not transfer");

	AST_FREQ_HOLD_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
		!(freq_strobe & pready) && !sync_load |=> $stable(active_freq))
		else $error("Active frequency changed without transfer");

	AST_PHASE_HOLD_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		!(phase_strobe & pready) && !sync_load |=> $stable(active_phase))
		else $error("Active phase changed without transfer");

	AST_CLEAR_ACC: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
		sample_strobe && config_reg[tnco_pkg::CFG_CLR_ACC_BIT]
		|=> acc_reg[ACC_WIDTH-1 -: 32] == $past(active_freq) + $past(gated_ofs))
		else $error("Accumulator feedback not zeroed");

	sequence s_zero_req;
		config_reg[tnco_pkg::CFG_LOAD_ZERO_BIT] && freq_strobe && pready;
	endsequence
	AST_LOAD_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		s_zero_req |=> zero_pend_reg)
		else $error("Load did not request accumulator zero");

	AST_OFS_OFF: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
		!config_reg[tnco_pkg::CFG_OFS_EN_BIT] ##1 !config_reg[tnco_pkg::CFG_OFS_EN_BIT]
		|-> gated_ofs == 32'h0000_0000)
		else $error("Offset frequency not gated off");

	AST_OFS_W8: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
		config_reg[tnco_pkg::CFG_OFS_W_HI:tnco_pkg::CFG_OFS_W_LO] == tnco_pkg::OFS_W8
		|=> gated_ofs[23:0] == 24'h00_0000)
		else $error("Offset width 8 leaks low bits");

	AST_WRITE_READY: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		wr_en |-> pready)
		else $error("Write access phase without ready");

	AST_READ_READY: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		rd_en |-> pready)
		else $error("Read access phase without ready");

	AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		pready |=> !pready)
		else $error("Ready held longer than one cycle");

	AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		pslverr |-> pready)
		else $error("Error response without ready");

	AST_CONFIG_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		wr_en && pready && paddr == tnco_pkg::ADDR_CONFIG
		|=> config_reg == $past(pwdata[tnco_pkg::CFG_WIDTH-1:0]))
		else $error("Configuration write did not land");

	AST_FREQ_HOLD_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
		wr_en && pready && paddr == tnco_pkg::ADDR_FREQ_HOLD
		|=> freq_hold_reg == $past(pwdata))
		else $error("Frequency hold write did not land");

	AST_PHASE_HOLD_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		wr_en && pready && paddr == tnco_pkg::ADDR_PHASE_HOLD
		|=> phase_hold_reg == $past(pwdata[tnco_pkg::PHASE_WIDTH-1:0]))
		else $error("Phase hold write did not land");

	sequence s_pin_rise;
		!external_sync_input ##1 external_sync_input [*2];
	endsequence
	AST_SYNC_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
		s_pin_rise |-> ##2 sync_pulse)
		else $error("Sync pin rise gave no internal pulse");

	sequence s_sync_zero_req;
		config_reg[tnco_pkg::CFG_LOAD_ZERO_BIT] && sync_load;
	endsequence
	AST_SYNC_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		s_sync_zero_req |=> zero_pend_reg)
		else $error("Sync load did not request accumulator zero");

	AST_ZERO_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		zero_pend_reg && sample_strobe && !((freq_strobe && pready) || sync_load)
		|=> !zero_pend_reg)
		else $error("Pending accumulator zero not cleared by sample");

	AST_ZERO_FEEDBACK: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		sample_strobe && zero_pend_reg
		|=> acc_reg[ACC_WIDTH-1 -: 32] == $past(active_freq) + $past(gated_ofs))
		else $error("Pending zero did not clear accumulator feedback");

	AST_OFS_W16: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
		config_reg[tnco_pkg::CFG_OFS_W_HI:tnco_pkg::CFG_OFS_W_LO] == tnco_pkg::OFS_W16
		|=> gated_ofs[15:0] == 16'h0000)
		else $error("Offset width 16 leaks low bits");

	AST_OFS_W24: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
		config_reg[tnco_pkg::CFG_OFS_W_HI:tnco_pkg::CFG_OFS_W_LO] == tnco_pkg::OFS_W24
		|=> gated_ofs[7:0] == 8'h00)
		else $error("Offset width 24 leaks low bits");

	AST_OFS_PASS: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
		config_reg[tnco_pkg::CFG_OFS_EN_BIT] && config_reg[4:3] == tnco_pkg::OFS_W32
		|=> gated_ofs == $past(offset_freq))
		else $error("Enabled full-width offset not passed through");

	AST_PHASE_OUT: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		sample_strobe && !config_reg[tnco_pkg::CFG_CLR_ACC_BIT] && !zero_pend_reg
		|=> phase_out == $past(acc_reg[ACC_WIDTH-1 -: 32]) + $past(active_freq)
			+ $past(gated_ofs) + {$past(active_phase), 24'h00_0000})
		else $error("Output phase is not accumulator plus frequency and offset");

	AST_VALID: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		sample_strobe |=> phase_valid)
		else $error("Sample gave no valid phase");

	AST_SYNC_PULSE_ONE: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
		sync_pulse |=> !sync_pulse)
		else $error("Sync pulse longer than one cycle");
endmodule // tnco_ctrl
`default_nettype wire

// >>> design/tnco_ofs_gate.sv
// Offset frequency width mask and enable gate
`timescale 1ns/1ns
`default_nettype none
module tnco_ofs_gate (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] ofs_in,
	input  wire logic [1:0]  width_sel,
	input  wire logic        enable,
	output logic      [31:0] ofs_out
);
	logic [31:0] mask;

	// Offset word is MSB aligned: the selected number of upper bits are kept
	always_comb begin
		unique case (width_sel)
			tnco_pkg::OFS_W8:  mask = 32'hFF00_0000; // [R04]
			tnco_pkg::OFS_W16: mask = 32'hFFFF_0000; // [R04]
			tnco_pkg::OFS_W24: mask = 32'hFFFF_FF00; // [R04]
			tnco_pkg::OFS_W32: mask = 32'hFFFF_FFFF; // [R04]
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ofs_out <= 32'h0000_0000;
		end else begin
			ofs_out <= enable ? (ofs_in & mask) : 32'h0000_0000; // [R05]
		end
	end
endmodule // tnco_ofs_gate
`default_nettype wire

// >>> design/tnco_sync.sv
// Two-flop synchroniser with rising-edge pulse for the external sync input
`timescale 1ns/1ns
`default_nettype none
module tnco_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output logic      rise_pulse
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	// Edge taken from the second flop only; first flop stays private
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_reg   <= 1'b0;
			rise_pulse <= 1'b0;
		end else begin
			last_reg   <= sync_reg;
			rise_pulse <= sync_reg & ~last_reg;
		end
	end
endmodule // tnco_sync
`default_nettype wire

// >>> inc/tnco_pkg.sv
// Package with register map, field layout and reset values of the timing oscillator control
package tnco_pkg;
	localparam logic [7:0]  ADDR_CONFIG      = 8'h2C;
	localparam logic [7:0]  ADDR_FREQ_HOLD   = 8'h30;
	localparam logic [7:0]  ADDR_PHASE_HOLD  = 8'h34;
	localparam logic [7:0]  ADDR_FREQ_STROBE = 8'h38;
	localparam logic [7:0]  ADDR_PHASE_STROBE= 8'h3C;
	localparam logic [7:0]  ADDR_STATUS      = 8'h40;
	localparam logic [7:0]  ADDR_ACC         = 8'h44;
	localparam int          CFG_SYNC_EN_BIT  = 5;
	localparam int          CFG_OFS_W_HI     = 4;
	localparam int          CFG_OFS_W_LO     = 3;
	localparam int          CFG_OFS_EN_BIT   = 2;
	localparam int          CFG_CLR_ACC_BIT  = 1;
	localparam int          CFG_LOAD_ZERO_BIT= 0;
	localparam int          CFG_WIDTH        = 6;
	localparam int          PHASE_WIDTH      = 8;
	localparam logic [31:0] CONFIG_RESET     = 32'h0000_0000;
	localparam logic [31:0] FREQ_RESET       = 32'h0000_0000;
	localparam logic [7:0]  PHASE_RESET      = 8'h00;
	localparam logic [1:0]  OFS_W8           = 2'h0;
	localparam logic [1:0]  OFS_W16          = 2'h1;
	localparam logic [1:0]  OFS_W24          = 2'h2;
	localparam logic [1:0]  OFS_W32          = 2'h3;
endpackage

// >>> tb/tnco_ctrl_tb.sv
// Self-checking bench for the timing oscillator control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("wrong value %s exp %h got %h", nm, exp, got); end end
module tnco_ctrl_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        sync_in, strobe, phase_valid;
	logic [7:0]  paddr, active_phase;
	logic [31:0] pwdata, prdata, ofs, phase_out, active_freq, rd, a, b;
	logic        err;
	int          n_mismatch = 0, num_checks = 0, cyc = 0;
	tnco_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_sync_input(sync_in), .sample_strobe(strobe),
		.offset_freq(ofs), .phase_out(phase_out), .phase_valid(phase_valid),
		.active_freq(active_freq), .active_phase(active_phase));
	tnco_far u_far (.pclk(pclk), .phase_valid(phase_valid), .phase_out(phase_out),
		.sample_strobe(strobe), .offset_freq(ofs), .external_sync_input(sync_in));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge: the next setup never re-drives psel in this time step
		@(posedge pclk);
	endtask
	// Phase advance over one sample
	task automatic step2(output logic [31:0] dl);
		u_far.sample(a);
		u_far.sample(b);
		dl = b - a;
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, tnco_pkg::ADDR_CONFIG, 32'h0000_0000);
		`CHK("config", 32'h0000_0000, rd)
		apb(1'b1, tnco_pkg::ADDR_FREQ_HOLD, 32'h1234_5678);
		apb(1'b1, tnco_pkg::ADDR_PHASE_HOLD, 32'hFFFF_FFAB);
		apb(1'b0, tnco_pkg::ADDR_PHASE_HOLD, 32'h0000_0000);
		`CHK("phase hold", 32'h0000_00AB, rd)
		apb(1'b0, tnco_pkg::ADDR_FREQ_HOLD, 32'h0000_0000);
		`CHK("freq hold", 32'h1234_5678, rd)
		`CHK("active freq", 32'h0000_0000, active_freq)
		`CHK("active phase", 8'h00, active_phase)
		apb(1'b1, tnco_pkg::ADDR_FREQ_STROBE, 32'hDEAD_BEEF);
		`CHK("active freq", 32'h1234_5678, active_freq)
		`CHK("active phase", 8'h00, active_phase)
		apb(1'b1, tnco_pkg::ADDR_PHASE_STROBE, 32'h0000_0000);
		`CHK("active phase", 8'hAB, active_phase)
		apb(1'b0, tnco_pkg::ADDR_FREQ_STROBE, 32'h0000_0000);
		`CHK("active freq read", 32'h1234_5678, rd)
		apb(1'b0, tnco_pkg::ADDR_PHASE_STROBE, 32'h0000_0000);
		`CHK("active phase read", 32'h0000_00AB, rd)
		apb(1'b0, 8'hF0, 32'h0000_0000);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0000_0000, rd)
		$display("test registers done");
		apb(1'b1, tnco_pkg::ADDR_FREQ_HOLD, 32'h0000_1000);
		apb(1'b1, tnco_pkg::ADDR_PHASE_HOLD, 32'h0000_0010);
		u_far.sync_pulse();
		`CHK("active freq", 32'h1234_5678, active_freq)
		`CHK("active phase", 8'hAB, active_phase)
		apb(1'b1, tnco_pkg::ADDR_CONFIG, 32'h0000_0020);
		u_far.sync_pulse();
		`CHK("active freq", 32'h0000_1000, active_freq)
		`CHK("active phase", 8'h10, active_phase)
		$display("test sync done");
		apb(1'b1, tnco_pkg::ADDR_CONFIG, 32'h0000_0000);
		u_far.offset_freq <= 32'hFFFF_FFFF;
		step2(rd);
		`CHK("advance", 32'h0000_1000, rd)
		`CHK("phase valid", 1'b1, phase_valid)
		for (int w = 0; w < 4; w++) begin
			apb(1'b1, tnco_pkg::ADDR_CONFIG, 32'(w * 8 + 4));
			step2(rd);
			`CHK("advance", 32'h0000_1000 + ~(32'hFFFF_FFFF >> (8 * w + 8)), rd)
		end
		$display("test offset done");
		u_far.offset_freq <= 32'h0000_0000;
		apb(1'b1, tnco_pkg::ADDR_CONFIG, 32'h0000_0002);
		step2(rd);
		`CHK("advance", 32'h0000_0000, rd)
		`CHK("phase", 32'h1000_1000, b)
		apb(1'b1, tnco_pkg::ADDR_CONFIG, 32'h0000_0001);
		step2(rd);
		apb(1'b1, tnco_pkg::ADDR_FREQ_HOLD, 32'h0000_2000);
		apb(1'b1, tnco_pkg::ADDR_FREQ_STROBE, 32'h0000_0000);
		apb(1'b0, tnco_pkg::ADDR_STATUS, 32'h0000_0000);
		`CHK("zero pending", 32'h0000_0001, rd)
		u_far.sample(a);
		`CHK("phase", 32'h1000_2000, a)
		apb(1'b0, tnco_pkg::ADDR_STATUS, 32'h0000_0000);
		`CHK("zero pending", 32'h0000_0000, rd)
		apb(1'b0, tnco_pkg::ADDR_ACC, 32'h0000_0000);
		`CHK("accumulator", 32'h0000_2000, rd)
		apb(1'b1, tnco_pkg::ADDR_FREQ_HOLD, 32'h0000_3000);
		apb(1'b1, tnco_pkg::ADDR_CONFIG, 32'h0000_0021);
		step2(rd);
		u_far.sync_pulse();
		`CHK("active freq", 32'h0000_3000, active_freq)
		u_far.sample(a);
		`CHK("phase", 32'h1000_3000, a)
		$display("test accumulator done");
		print_verdict();
	end
endmodule // tnco_ctrl_tb
`default_nettype wire

// >>> tb/tnco_far.sv
// Far-side model: sample source, offset word and external sync pin
`timescale 1ns/1ns
`default_nettype none
module tnco_far (
	input  wire logic        pclk,
	input  wire logic        phase_valid,
	input  wire logic [31:0] phase_out,
	output logic             sample_strobe,
	output logic      [31:0] offset_freq,
	output logic             external_sync_input
);
	initial begin
		sample_strobe = 1'b0;
		offset_freq = 32'h0000_0000;
		external_sync_input = 1'b0;
	end
	// One-cycle sample pulse, then the phase that it produced
	task automatic sample(output logic [31:0] ph);
		int n;
		sample_strobe <= 1'b1;
		@(posedge pclk);
		sample_strobe <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (phase_valid !== 1'b1 && n < 10);
		ph = phase_out;
	endtask
	// Held three cycles so the two-flop stage surely sees it
	task automatic sync_pulse();
		external_sync_input <= 1'b1;
		repeat (3) @(posedge pclk);
		external_sync_input <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
endmodule // tnco_far
`default_nettype wire
